//--- include/phy_ctrl_if.sv
// Reset sequencing signals passed between the sequencer and the mode core
`timescale 1ns/1ps
interface phy_ctrl_if;
  logic       hardware_reset_mode;
  logic [2:0] cfgSampled;
  logic       cfgLoad;

  modport seq  (output hardware_reset_mode, output cfgSampled, output cfgLoad);
  modport core (input hardware_reset_mode, input cfgSampled, input cfgLoad);
endinterface

//--- include/phy_mode_pkg.sv
// Constants and types shared by the transceiver mode and start-up logic
package phy_mode_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int RESET_EXT_NS       = 258000;
  localparam int RESET_EXT_CYCLES   = (RESET_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MII_HALF_100_NS    = 20;
  localparam int MII_HALF_10_NS     = 200;
  localparam int MII_HALF_100_CYC   = MII_HALF_100_NS / CLK_PERIOD_NS;
  localparam int MII_HALF_10_CYC    = MII_HALF_10_NS / CLK_PERIOD_NS;
  localparam int MII_DIV_W          = 8;

  // ---------------------------------------------------------------------------
  // Configuration pin positions (sampled from the LED pins)
  // ---------------------------------------------------------------------------
  localparam int CFG_AUTONEG_BIT    = 0;
  localparam int CFG_SPEED_BIT      = 1;
  localparam int CFG_DUPLEX_BIT     = 2;
  localparam logic [2:0] CFG_RESET_VAL = 3'h1;

  // ---------------------------------------------------------------------------
  // Ability bit positions: advertised and partner
  // ---------------------------------------------------------------------------
  localparam int AB_10H  = 0;
  localparam int AB_10F  = 1;
  localparam int AB_100H = 2;
  localparam int AB_100F = 3;
  localparam logic [3:0] ADV_ALL = 4'hf;

  // ---------------------------------------------------------------------------
  // LED status selection codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] LED_SPEED  = 4'h0;
  localparam logic [3:0] LED_LINK   = 4'h1;
  localparam logic [3:0] LED_DUPLEX = 4'h2;
  localparam logic [3:0] LED_RXACT  = 4'h3;
  localparam logic [3:0] LED_TXACT  = 4'h4;
  localparam logic [3:0] LED_COLL   = 4'h5;
  localparam logic [3:0] LED_ON     = 4'h6;
  localparam logic [3:0] LED_OFF    = 4'h7;
  localparam int LED_COUNT = 3;

  // ---------------------------------------------------------------------------
  // Pin-state modes and link start-up states
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    PM_NORMAL  = 5'b00001,
    PM_SWPDN   = 5'b00010,
    PM_ISOLATE = 5'b00100,
    PM_HARDWARE_RESET_MODE = 5'b01000,
    PM_HWPDN   = 5'b10000
  } pin_mode_t;

  typedef enum logic [4:0] {
    LS_IDLE   = 5'b00001,
    LS_SAMPLE = 5'b00010,
    LS_FORCED = 5'b00100,
    LS_AUTO   = 5'b01000,
    LS_LINK   = 5'b10000
  } link_state_t;

endpackage

//--- rtl/phy_mode_core.sv
// MII pin-state control, link start-up resolution and LED drivers
`timescale 1ns/1ps

module phy_mode_core #(
  parameter int RESET_EXT_CYCLES = phy_mode_pkg::RESET_EXT_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic resetPinN,
  input  wire logic ctrlResetBit,
  input  wire logic power_down_pin,
  input  wire logic isolateBit,
  input  wire logic swPowerDownBit,
  input  wire logic [11:0] ledConfig,
  input  wire logic [2:0] ledPinIn,
  output logic      [2:0] ledPinOut,
  output logic      [2:0] ledPinOeN,
  input  wire logic partnerFlp,
  input  wire logic [3:0] partnerAbility,
  input  wire logic linkPulseSeen,
  input  wire logic idleSeen,
  input  wire logic linkLost,
  output logic      sendFlp,
  output logic      [3:0] advAbility,
  input  wire logic [3:0] lineRxd,
  input  wire logic lineRxDv,
  input  wire logic lineRxEr,
  input  wire logic lineCol,
  input  wire logic lineCrs,
  input  wire logic txEnIn,
  output logic      [3:0] rxdOut,
  output logic      rxDvOut,
  output logic      rxErOut,
  output logic      colOut,
  output logic      crsOut,
  output logic      txClkOut,
  output logic      rxClkOut,
  output logic      miiOutOeN,
  output logic      miiOutPullDown,
  output logic      txInPullDown,
  output logic      speed100,
  output logic      fullDuplex,
  output logic      linkUp
);
  import phy_mode_pkg::*;

  phy_ctrl_if ctrl ();

  phy_reset_seq #(.EXT_CYCLES(RESET_EXT_CYCLES)) u_seq (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .resetPinN    (resetPinN),
    .ctrlResetBit (ctrlResetBit),
    .ledPinIn     (ledPinIn),
    .ctrl         (ctrl.seq)
  );

  // ---------------------------------------------------------------------------
  // Pin-state mode with fixed precedence
  // ---------------------------------------------------------------------------
  pin_mode_t mode;

  always_comb begin
    if (power_down_pin)                mode = PM_HWPDN;
    else if (ctrl.hardware_reset_mode) mode = PM_HARDWARE_RESET_MODE;
    else if (isolateBit)               mode = PM_ISOLATE;
    else if (swPowerDownBit)           mode = PM_SWPDN;
    else                               mode = PM_NORMAL;
  end

  // ---------------------------------------------------------------------------
  // Link start-up
  // ---------------------------------------------------------------------------
  link_state_t state_reg;
  wire logic   cfgAuto = ctrl.cfgSampled[CFG_AUTONEG_BIT];

  // Hardware power-down and reset drop the link; the straps are only re-read after a reset
  always_ff @(posedge clk_sys) begin
    if (rst || mode == PM_HWPDN || ctrl.hardware_reset_mode) begin
      state_reg <= LS_IDLE;
    end else begin
      unique case (state_reg)
        LS_IDLE:   state_reg <= LS_SAMPLE;
        LS_SAMPLE: state_reg <= cfgAuto ? LS_AUTO : LS_FORCED;
        LS_FORCED: state_reg <= linkLost ? LS_FORCED : LS_LINK;
        LS_AUTO: begin
          if (partnerFlp || linkPulseSeen || idleSeen) begin
            state_reg <= LS_LINK;
          end
        end
        LS_LINK: begin
          if (linkLost) begin
            state_reg <= cfgAuto ? LS_AUTO : LS_FORCED;
          end
        end
      endcase
    end
  end

  wire logic [3:0] common = ADV_ALL & partnerAbility;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      speed100   <= 1'b0;
      fullDuplex <= 1'b0;
    end else if (state_reg == LS_SAMPLE && !cfgAuto) begin
      speed100   <= ctrl.cfgSampled[CFG_SPEED_BIT];
      fullDuplex <= ctrl.cfgSampled[CFG_DUPLEX_BIT];
    end else if (state_reg == LS_AUTO) begin
      if (partnerFlp) begin
        speed100   <= common[AB_100F] || common[AB_100H];
        fullDuplex <= common[AB_100F] || (!common[AB_100H] && common[AB_10F]);
      end else if (idleSeen) begin
        speed100   <= 1'b1;
        fullDuplex <= 1'b0;
      end else if (linkPulseSeen) begin
        speed100   <= 1'b0;
        fullDuplex <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sendFlp    <= 1'b0;
      advAbility <= 4'h0;
      linkUp     <= 1'b0;
    end else begin
      sendFlp    <= (state_reg == LS_AUTO);
      advAbility <= ADV_ALL;
      linkUp     <= (state_reg == LS_LINK);
    end
  end

  // ---------------------------------------------------------------------------
  // MII clock divider; its clock reaches the pins in normal mode and software power-down only
  // ---------------------------------------------------------------------------
  logic [MII_DIV_W-1:0] div_reg;
  logic                 miiClk_reg;
  wire logic [MII_DIV_W-1:0] halfCyc =
    speed100 ? MII_DIV_W'(MII_HALF_100_CYC) : MII_DIV_W'(MII_HALF_10_CYC);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_reg    <= '0;
      miiClk_reg <= 1'b1;
    end else if (div_reg >= halfCyc - MII_DIV_W'(1)) begin
      div_reg    <= '0;
      miiClk_reg <= !miiClk_reg;
    end else begin
      div_reg <= div_reg + MII_DIV_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // MII pin states
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {rxdOut, rxDvOut, rxErOut, colOut, crsOut} <= 8'h00;
      txClkOut       <= 1'b1;
      rxClkOut       <= 1'b1;
      miiOutOeN      <= 1'b0;
      miiOutPullDown <= 1'b0;
      txInPullDown   <= 1'b1;
    end else begin
      unique case (mode)
        PM_HARDWARE_RESET_MODE: begin
          {rxdOut, rxDvOut, rxErOut, colOut, crsOut} <= 8'h00;
          txClkOut       <= 1'b1;
          rxClkOut       <= 1'b1;
          miiOutOeN      <= 1'b0;
          miiOutPullDown <= 1'b0;
          txInPullDown   <= 1'b1;
        end
        PM_SWPDN: begin
          {rxdOut, rxDvOut, rxErOut, colOut, crsOut} <= 8'h00;
          txClkOut       <= miiClk_reg;
          rxClkOut       <= miiClk_reg;
          miiOutOeN      <= 1'b0;
          miiOutPullDown <= 1'b0;
          txInPullDown   <= 1'b1;
        end
        PM_ISOLATE: begin
          {rxdOut, rxDvOut, rxErOut, colOut, crsOut} <= 8'h00;
          txClkOut       <= 1'b0;
          rxClkOut       <= 1'b0;
          miiOutOeN      <= 1'b1;
          miiOutPullDown <= 1'b1;
          txInPullDown   <= 1'b1;
        end
        PM_HWPDN: begin
          {rxdOut, rxDvOut, rxErOut, colOut, crsOut} <= 8'h00;
          txClkOut       <= 1'b0;
          rxClkOut       <= 1'b0;
          miiOutOeN      <= 1'b1;
          miiOutPullDown <= 1'b0;
          txInPullDown   <= 1'b0;
        end
        PM_NORMAL: begin
          rxdOut         <= lineRxd;
          rxDvOut        <= lineRxDv;
          rxErOut        <= lineRxEr;
          colOut         <= lineCol && !fullDuplex;
          crsOut         <= lineCrs;
          txClkOut       <= miiClk_reg;
          rxClkOut       <= miiClk_reg;
          miiOutOeN      <= 1'b0;
          miiOutPullDown <= 1'b0;
          txInPullDown   <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // LED drivers; released while straps must be readable
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < LED_COUNT; i++) begin : g_led
    wire logic [3:0] sel = ledConfig[4*i +: 4];
    logic            status;
    always_comb begin
      case (sel)
        LED_SPEED:  status = speed100;
        LED_LINK:   status = linkUp;
        LED_DUPLEX: status = fullDuplex;
        LED_RXACT:  status = lineCrs;
        LED_TXACT:  status = txEnIn;
        LED_COLL:   status = lineCol;
        LED_ON:     status = 1'b1;
        default:    status = 1'b0;
      endcase
    end
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        ledPinOut[i] <= 1'b0;
        ledPinOeN[i] <= 1'b1;
      end else begin
        ledPinOut[i] <= status;
        ledPinOeN[i] <= ctrl.hardware_reset_mode || power_down_pin;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_pins : assert property (
    (ctrl.hardware_reset_mode && !power_down_pin) |=> (rxdOut == 4'h0 && !rxDvOut && !rxErOut
      && !colOut && !crsOut && txClkOut && rxClkOut && !miiOutOeN))
    else $error("reset pin levels wrong");
  a_tx_pulldown : assert property (
    (mode == PM_HARDWARE_RESET_MODE || mode == PM_SWPDN || mode == PM_ISOLATE) |=> txInPullDown)
    else $error("transmit inputs not pulled down");
  a_pdn_highz : assert property (
    power_down_pin |=> (miiOutOeN && !miiOutPullDown && !txInPullDown && ledPinOeN == 3'h7))
    else $error("power-down pins not released");
  a_isolate_hz : assert property (
    (isolateBit && !ctrl.hardware_reset_mode && !power_down_pin)
      |=> (miiOutOeN && miiOutPullDown && txInPullDown))
    else $error("isolate pin states wrong");
  a_forced_path : assert property (
    (state_reg == LS_SAMPLE && !cfgAuto && mode != PM_HWPDN && !ctrl.hardware_reset_mode)
      |=> (state_reg == LS_FORCED && speed100 == $past(ctrl.cfgSampled[CFG_SPEED_BIT])))
    else $error("forced configuration not applied");
  a_auto_path : assert property (
    (state_reg == LS_SAMPLE && cfgAuto && mode != PM_HWPDN && !ctrl.hardware_reset_mode)
      |=> state_reg == LS_AUTO ##1 sendFlp)
    else $error("automatic resolution not entered");
  a_flp_send : assert property (
    $rose(state_reg == LS_AUTO) |=> sendFlp && advAbility == ADV_ALL)
    else $error("FLP bursts not started");
  a_parallel_det : assert property (
    (state_reg == LS_AUTO && !partnerFlp && (idleSeen || linkPulseSeen)
      && mode != PM_HWPDN && !ctrl.hardware_reset_mode)
      |=> (speed100 == $past(idleSeen) && !fullDuplex))
    else $error("parallel detection speed wrong");
  a_led_select : assert property (
    (ledConfig[3:0] == LED_LINK && !ctrl.hardware_reset_mode) |=> ledPinOut[0] == $past(linkUp))
    else $error("LED does not follow selection");
endmodule

//--- rtl/phy_reset_seq.sv
// Reset stretcher and configuration pin sampler
`timescale 1ns/1ps
module phy_reset_seq #(
  parameter int EXT_CYCLES = phy_mode_pkg::RESET_EXT_CYCLES
) (
  input  wire logic  clk_sys,
  input  wire logic  rst,
  input  wire logic  resetPinN,
  input  wire logic  ctrlResetBit,
  input  wire logic  [2:0] ledPinIn,
  phy_ctrl_if.seq    ctrl
);
  import phy_mode_pkg::*;

  localparam int CW = $clog2(EXT_CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic          resetSrc;

  assign resetSrc = !resetPinN || ctrlResetBit;

  // ---------------------------------------------------------------------------
  // Stretch reset past the release of every source
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_reg                <= CW'(EXT_CYCLES);
      ctrl.hardware_reset_mode <= 1'b1;
    end else if (resetSrc) begin
      count_reg                <= CW'(EXT_CYCLES);
      ctrl.hardware_reset_mode <= 1'b1;
    end else if (count_reg != '0) begin
      count_reg                <= count_reg - CW'(1);
      ctrl.hardware_reset_mode <= 1'b1;
    end else begin
      ctrl.hardware_reset_mode <= 1'b0;
    end
  end

  // Straps are caught one cycle before the last stretched cycle, while the LED pins are released
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl.cfgSampled <= CFG_RESET_VAL;
      ctrl.cfgLoad    <= 1'b0;
    end else begin
      ctrl.cfgLoad <= 1'b0;
      if (!resetSrc && count_reg == CW'(1)) begin
        ctrl.cfgSampled <= ledPinIn;
        ctrl.cfgLoad    <= 1'b1;
      end
    end
  end

  a_reset_entry : assert property (@(posedge clk_sys) disable iff (rst)
    resetSrc |=> ctrl.hardware_reset_mode)
    else $error("reset source did not hold hardware reset");

  a_reset_stretch : assert property (@(posedge clk_sys) disable iff (rst)
    $fell(resetSrc) |-> ctrl.hardware_reset_mode [*8])
    else $error("reset released before stretch elapsed");

  a_strap_sample : assert property (@(posedge clk_sys) disable iff (rst)
    $fell(ctrl.hardware_reset_mode) |-> ctrl.cfgSampled == $past(ledPinIn, 2))
    else $error("strap value not taken at reset release");

  a_strap_load : assert property (@(posedge clk_sys) disable iff (rst)
    $fell(ctrl.hardware_reset_mode) |-> $past(ctrl.cfgLoad))
    else $error("strap load strobe missing before reset release");
endmodule

//--- sim/phy_line_model.sv
// Link partner model: answers FLP bursts or shows link pulses or idle
`timescale 1ns/1ps
module phy_line_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] partnerMode,
  input  wire logic [3:0] abilSet,
  input  wire logic       sendFlp,
  output logic            partnerFlp,
  output logic      [3:0] partnerAbility,
  output logic            linkPulseSeen,
  output logic            idleSeen
);
  // ---------------------------------------------------------------
  // Line activity, mode 1 negotiates, 2 idle only, 3 pulses only
  // ---------------------------------------------------------------
  initial begin
    partnerFlp = 1'b0;
    partnerAbility = 4'h0;
    linkPulseSeen = 1'b0;
    idleSeen = 1'b0;
  end
  always @(negedge clk_sys) begin
    // A partner only bursts back while bursts are being sent
    partnerFlp <= (partnerMode == 2'h1) && sendFlp;
    // Abilities are junk outside a burst, so show their inverse
    partnerAbility <= (partnerMode == 2'h1 && sendFlp) ? abilSet : ~abilSet;
    idleSeen <= (partnerMode == 2'h2);
    linkPulseSeen <= (partnerMode == 2'h3);
  end
endmodule

//--- sim/test_phy_mode_core.sv
// Self-checking bench for the MII pin-state and link start-up logic
`timescale 1ns/1ps
module test_phy_mode_core;
  import phy_mode_pkg::*;
  // Short stretch so each reset takes a few tens of cycles
  localparam int EXT = 20;
  // Expected LED level per status code while speed, link, duplex, carrier and transmit are high
  localparam logic [7:0] LED_LEVELS = 8'h5f;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        resetPinN = 1'b1;
  logic        ctrlResetBit = 1'b0;
  logic        power_down_pin = 1'b0;
  logic        isolateBit = 1'b0;
  logic        swPowerDownBit = 1'b0;
  logic [11:0] ledConfig = 12'h000;
  logic [2:0]  straps = 3'h1;
  logic [1:0]  partnerMode = 2'h0;
  logic [3:0]  abilSet = 4'h0;
  logic        linkLost = 1'b0;
  logic [3:0]  lineRxd = 4'h0;
  logic        lineRxDv = 1'b1;
  logic        lineRxEr = 1'b0;
  logic        lineCol = 1'b0;
  logic        lineCrs = 1'b1;
  logic        txEnIn = 1'b1;
  wire  [2:0]  ledPinIn, ledPinOut, ledPinOeN;
  wire  [3:0]  partnerAbility, advAbility, rxdOut;
  wire         partnerFlp, linkPulseSeen, idleSeen, sendFlp;
  wire         rxDvOut, rxErOut, colOut, crsOut, txClkOut, rxClkOut;
  wire         miiOutOeN, miiOutPullDown, txInPullDown;
  wire         speed100, fullDuplex, linkUp;
  int          fails = 0;
  int          nCompared = 0;
  int          i;
  int          k;
  logic [3:0]  abTab [4] = '{4'h1, 4'h3, 4'h5, 4'hf};
  logic [1:0]  sdTab [4] = '{2'b00, 2'b01, 2'b10, 2'b11};

  always #5 clk_sys = ~clk_sys;
  // Released LED pins show the board straps, driven ones their own level
  assign ledPinIn = (straps & ledPinOeN) | (ledPinOut & ~ledPinOeN);

  phy_mode_core #(.RESET_EXT_CYCLES(EXT)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .resetPinN(resetPinN), .ctrlResetBit(ctrlResetBit),
    .power_down_pin(power_down_pin), .isolateBit(isolateBit),
    .swPowerDownBit(swPowerDownBit), .ledConfig(ledConfig), .ledPinIn(ledPinIn),
    .ledPinOut(ledPinOut), .ledPinOeN(ledPinOeN), .partnerFlp(partnerFlp),
    .partnerAbility(partnerAbility), .linkPulseSeen(linkPulseSeen),
    .idleSeen(idleSeen), .linkLost(linkLost), .sendFlp(sendFlp),
    .advAbility(advAbility), .lineRxd(lineRxd), .lineRxDv(lineRxDv),
    .lineRxEr(lineRxEr), .lineCol(lineCol), .lineCrs(lineCrs), .txEnIn(txEnIn),
    .rxdOut(rxdOut), .rxDvOut(rxDvOut), .rxErOut(rxErOut), .colOut(colOut),
    .crsOut(crsOut), .txClkOut(txClkOut), .rxClkOut(rxClkOut),
    .miiOutOeN(miiOutOeN), .miiOutPullDown(miiOutPullDown),
    .txInPullDown(txInPullDown), .speed100(speed100), .fullDuplex(fullDuplex),
    .linkUp(linkUp)
  );
  phy_line_model i_line (
    .clk_sys(clk_sys), .partnerMode(partnerMode), .abilSet(abilSet),
    .sendFlp(sendFlp), .partnerFlp(partnerFlp), .partnerAbility(partnerAbility),
    .linkPulseSeen(linkPulseSeen), .idleSeen(idleSeen)
  );

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [6:0] pins();
    return {miiOutOeN, miiOutPullDown, txInPullDown, txClkOut, rxClkOut, crsOut, rxDvOut};
  endfunction
  // Reset through the control bit, then wait for the link to come up
  task automatic bring_up(input logic [2:0] s, input logic [1:0] pm, input logic [3:0] ab);
    int n;
    straps = s;
    partnerMode = pm;
    abilSet = ab;
    ctrlResetBit = 1'b1;
    // Long enough for the previous link indication to drop first
    step(4);
    ctrlResetBit = 1'b0;
    for (n = 0; n < 300 && linkUp !== 1'b1; n++) step(1);
    if (linkUp !== 1'b1) begin
      fails++;
      $display("FAIL linkUp expected 1 seen %b", linkUp);
      summarize();
    end
  endtask
  // Clocks are ignored where they are meant to run
  task automatic mode_chk(input logic [3:0] m, input logic [6:0] exp);
    logic [6:0] msk;
    {power_down_pin, isolateBit, swPowerDownBit} = m[3:1];
    resetPinN = ~m[0];
    step(3);
    msk = (!exp[6] && exp[3:2] == 2'b00) ? 7'h73 : 7'h7f;
    chk("mii pins", {5'h0, exp & msk}, {5'h0, pins() & msk});
    {power_down_pin, isolateBit, swPowerDownBit} = 3'h0;
    resetPinN = 1'b1;
  endtask
  task automatic clk_runs();
    logic t;
    int n;
    t = txClkOut;
    for (n = 0; n < 50 && txClkOut === t; n++) step(1);
    chk("txClk toggles", 12'h1, {11'h0, txClkOut !== t});
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    step(16);
    chk("mii pins in reset", 12'h01c, {5'h0, pins()});
    chk("led released", 12'h7, {9'h0, ledPinOeN});
    resetPinN = 1'b0;
    rst = 1'b0;
    step(5);
    chk("mii pins pin reset", 12'h01c, {5'h0, pins()});
    resetPinN = 1'b1;
    step(EXT - 2);
    chk("led still released", 12'h7, {9'h0, ledPinOeN});
    for (i = 0; i < 10 && ledPinOeN !== 3'h0; i++) step(1);
    chk("stretch ended", 12'h0, {9'h0, ledPinOeN});
    step(3);
    chk("flp sent", 12'h1, {11'h0, sendFlp});
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      bring_up({sdTab[i][0], sdTab[i][1], 1'b0}, 2'h3, 4'h0);
      chk("forced mode", {10'h0, sdTab[i]}, {10'h0, speed100, fullDuplex});
      lineCol = 1'b1;
      lineRxEr = 1'b1;
      lineRxd = abTab[i];
      step(3);
      chk("col masked", {11'h0, ~sdTab[i][0]}, {11'h0, colOut});
      chk("rxd through", {8'h0, abTab[i]}, {8'h0, rxdOut});
      chk("rxer through", 12'h1, {11'h0, rxErOut});
      lineCol = 1'b0;
      lineRxEr = 1'b0;
    end
    $display("test forced done");
    for (i = 0; i < 4; i++) begin
      bring_up(3'h1, 2'h1, abTab[i]);
      chk("negotiated", {10'h0, sdTab[i]}, {10'h0, speed100, fullDuplex});
      chk("advertised", 12'hf, {8'h0, advAbility});
    end
    linkLost = 1'b1;
    step(3);
    chk("link dropped", 12'h0, {11'h0, linkUp});
    linkLost = 1'b0;
    bring_up(3'h1, 2'h2, 4'h0);
    chk("idle detect", 12'h2, {10'h0, speed100, fullDuplex});
    bring_up(3'h1, 2'h3, 4'h0);
    chk("pulse detect", 12'h0, {10'h0, speed100, fullDuplex});
    $display("test autoneg done");
    bring_up(3'h6, 2'h0, 4'h0);
    for (i = 0; i < 8; i++) begin
      ledConfig = {4'(i + 2), 4'(i + 1), 4'(i)};
      step(3);
      for (k = 0; k < 3; k++)
        chk("led out", {11'h0, (i + k < 8) && LED_LEVELS[i + k]}, {11'h0, ledPinOut[k]});
    end
    $display("test leds done");
    mode_chk(4'h0, 7'b0000011);
    mode_chk(4'h2, 7'b0010000);
    swPowerDownBit = 1'b1;
    clk_runs();
    swPowerDownBit = 1'b0;
    mode_chk(4'h4, 7'b1110000);
    mode_chk(4'h6, 7'b1110000);
    mode_chk(4'he, 7'b1000000);
    mode_chk(4'h5, 7'b0011100);
    mode_chk(4'h9, 7'b1000000);
    $display("test pin modes done");
    summarize();
  end
endmodule
